// ### include/hbh_pkg.sv
// Purpose: shared constants and types of the host bus handshake and decode block
// Assumes: core clock of 40 MHz, host bus clock sampled as an ordinary pin
// Notes:   pin vector positions describe the bundle fed to the synchroniser
package hbh_pkg;

  // clock figures
  localparam int CLK_MHZ      = 40;
  localparam int BCLK_MAX_MHZ = 50;

  // address decode window, bits 15 down to 4
  localparam int ADDR_HI      = 15;
  localparam int ADDR_LO      = 4;
  localparam int ADDR_W       = ADDR_HI - ADDR_LO + 1;

  // positions in the synchronised pin bundle
  localparam int PIN_BCLK     = 0;
  localparam int PIN_STRAP    = 1;
  localparam int PIN_RDYRET   = 2;
  localparam int PIN_CYCLE    = 3;
  localparam int PIN_DSEL     = 4;
  localparam int PIN_AEN      = 5;
  localparam int PIN_ADDR     = 6;
  localparam int PIN_W        = PIN_ADDR + ADDR_W;

  // synchroniser depth
  localparam int SYNC_STAGES  = 2;

  // values after reset
  localparam logic RST_READY_N = 1'b1;
  localparam logic RST_IRQ_N   = 1'b1;
  localparam logic RST_STRAP   = 1'b0;

  // handshake states of the synchronous ready sequence
  typedef enum logic [1:0] {
    ST_IDLE,
    ST_WAIT,
    ST_READY
  } hbh_state_e;

endpackage

// ### hdl/hbh_sync.sv
// Purpose: two-flop synchroniser for a bundle of host pins
// Assumes: each bit is an independent level
// Notes:   stage one feeds stage two only
`timescale 1ns/1ps
module hbh_sync
  import hbh_pkg::*;
#(
  parameter int WIDTH = 1
) (
  input  wire logic             clk_i,
  input  wire logic             reset_n_i,
  input  wire logic [WIDTH-1:0] d_i,
  input  wire logic [WIDTH-1:0] rst_val_i,
  output logic      [WIDTH-1:0] q_o
);

  logic [WIDTH-1:0] meta_q;
  logic [WIDTH-1:0] stab_q;

  // two stages, reset to idle (pins reset high where inactive-high)
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      meta_q <= '0;
      stab_q <= '0;
    end else begin
      meta_q <= d_i ^ rst_val_i;
      stab_q <= meta_q;
    end
  end

  // rst_val flips polarity so active-low pins read inactive after reset
  assign q_o = stab_q ^ rst_val_i;

endmodule

// ### hdl/hbh_top.sv
// Purpose: host bus ready handshakes, data port select, interrupt pin, local decode
// Assumes: bus clock pin is slow enough to be sampled by clk_i; core_ready_i and
//          irq_status_i come from logic on clk_i
// Notes:   local_device_hit_n_o is deliberately combinational
`timescale 1ns/1ps
module hbh_top
  import hbh_pkg::*;
#(
  parameter int IRQ_W = 16
) (
  input  wire logic              clk_i,
  input  wire logic              reset_n_i,
  input  wire logic              bclk_i,
  input  wire logic              bus_mode_strap_i,
  input  wire logic              host_ready_return_n_i,
  input  wire logic              cycle_indicator_n_i,
  input  wire logic              data_port_select_n_i,
  input  wire logic              address_enable_i,
  input  wire logic [ADDR_HI:1]  addr_i,
  input  wire logic [15:0]       base_addr_i,
  input  wire logic              bus_32bit_i,
  input  wire logic              burst_mode_i,
  input  wire logic              core_ready_i,
  input  wire logic [IRQ_W-1:0]  irq_status_i,
  output logic                   sync_ready_n_o,
  output logic                   irq_out_n_o,
  output logic                   local_device_hit_n_o,
  output logic                   data_high_sel_o,
  output logic                   data_low_sel_o,
  output logic                   bus_burst_mode_o,
  output logic                   cycle_active_o
);

  // address match against the base register, used by both decodes
  function automatic logic addr_match(input logic [ADDR_W-1:0] a,
                                      input logic [15:0]       base);
    addr_match = (a == base[ADDR_HI:ADDR_LO]);
  endfunction

  logic [PIN_W-1:0] pins_raw;
  logic [PIN_W-1:0] pins_s;
  logic [PIN_W-1:0] pins_rst;
  logic             bclk_prev_q;
  logic             bclk_rise;
  logic             strap_q;
  logic             strap_done_q;
  logic [1:0]       strap_cnt_q;
  logic             burst_act;
  logic             selected_s;
  hbh_state_e       state_q;

  // pins into one bundle; active-low pins reset to inactive high
  assign pins_raw = {addr_i[ADDR_HI:ADDR_LO], address_enable_i, data_port_select_n_i,
                     cycle_indicator_n_i, host_ready_return_n_i, bus_mode_strap_i, bclk_i};
  assign pins_rst = {{ADDR_W{1'b0}}, 1'b1, 1'b1, 1'b1, 1'b1, 1'b0, 1'b0};

  hbh_sync #(
    .WIDTH (PIN_W)
  ) u_sync (
    .clk_i     (clk_i),
    .reset_n_i (reset_n_i),
    .d_i       (pins_raw),
    .rst_val_i (pins_rst),
    .q_o       (pins_s)
  );

  // bus clock edge finder on the synchronised copy
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      bclk_prev_q <= 1'b0;
    end else begin
      bclk_prev_q <= pins_s[PIN_BCLK];
    end
  end

  assign bclk_rise = pins_s[PIN_BCLK] && !bclk_prev_q;

  // strap caught once, after the synchroniser has filled with the pin level
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      strap_q      <= RST_STRAP;
      strap_done_q <= 1'b0;
      strap_cnt_q  <= '0;
    end else if (!strap_done_q) begin
      strap_cnt_q  <= strap_cnt_q + 2'd1;
      strap_done_q <= (strap_cnt_q == 2'(SYNC_STAGES)); // reset contents flushed out
      strap_q      <= pins_s[PIN_STRAP];
    end
  end

  // burst handshake applies only to a strapped 32-bit burst interface
  assign burst_act  = strap_q && bus_32bit_i && burst_mode_i;
  assign selected_s = (!pins_s[PIN_AEN] &&
                       addr_match(pins_s[PIN_W-1:PIN_ADDR], base_addr_i)) ||
                      (bus_32bit_i && !pins_s[PIN_DSEL]);

  // synchronous ready sequence, stepped only on bus clock rises
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      state_q <= ST_IDLE;
    end else if (bclk_rise && !strap_q) begin
      case (state_q)
        ST_IDLE: begin
          if (!pins_s[PIN_CYCLE] && selected_s) begin
            state_q <= ST_WAIT;
          end
        end
        ST_WAIT: begin
          if (core_ready_i) begin
            state_q <= ST_READY;
          end
        end
        ST_READY: begin
          if (!pins_s[PIN_RDYRET]) begin
            state_q <= ST_IDLE;
          end
        end
        default: begin
          state_q <= ST_IDLE;
        end
      endcase
    end
  end

  // ready pin: VL falls on ready, burst holds low through waits
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      sync_ready_n_o <= RST_READY_N;
    end else if (bclk_rise) begin
      if (burst_act) begin
        sync_ready_n_o <= !(selected_s && !core_ready_i);
      end else if (!strap_q) begin
        sync_ready_n_o <= !((state_q == ST_WAIT && core_ready_i) ||
                            (state_q == ST_READY && pins_s[PIN_RDYRET]));
      end else begin
        sync_ready_n_o <= RST_READY_N;
      end
    end
  end

  // cycle activity and mode report
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      cycle_active_o   <= 1'b0;
      bus_burst_mode_o <= 1'b0;
    end else begin
      cycle_active_o   <= (state_q != ST_IDLE) || (burst_act && selected_s);
      bus_burst_mode_o <= burst_act;
    end
  end

  // interrupt pin follows any set status bit
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      irq_out_n_o <= RST_IRQ_N;
    end else begin
      irq_out_n_o <= ~|irq_status_i;
    end
  end

  // data port select bypasses address, enable and bank; 32-bit only
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      data_high_sel_o <= 1'b0;
      data_low_sel_o  <= 1'b0;
    end else begin
      data_high_sel_o <= bus_32bit_i && !pins_s[PIN_DSEL];
      data_low_sel_o  <= bus_32bit_i && !pins_s[PIN_DSEL];
    end
  end

  // local device decode straight from the pins, no flop
  assign local_device_hit_n_o = !(!address_enable_i &&
                                  addr_match(addr_i[ADDR_HI:ADDR_LO], base_addr_i));

  // checks
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!reset_n_i);

  sequence s_vl_go;
    !strap_q && bclk_rise && state_q == ST_WAIT && core_ready_i;
  endsequence

  sequence s_vl_hold;
    state_q == ST_READY && !bclk_rise;
  endsequence

  property p_vl_fall;
    s_vl_go |=> $fell(sync_ready_n_o);
  endproperty
  a_vl_fall: assert property (p_vl_fall) else $error("ready did not fall");

  property p_vl_hold;
    s_vl_hold |=> !sync_ready_n_o;
  endproperty
  a_vl_hold: assert property (p_vl_hold) else $error("ready dropped early");

  property p_step;
    $changed(sync_ready_n_o) |-> $past(bclk_rise);
  endproperty
  a_step: assert property (p_step) else $error("ready moved off bus clock");

  property p_burst;
    burst_act && bclk_rise && selected_s && !core_ready_i |=> !sync_ready_n_o;
  endproperty
  a_burst: assert property (p_burst) else $error("burst wait missing");

  property p_irq;
    |irq_status_i |=> !irq_out_n_o;
  endproperty
  a_irq: assert property (p_irq) else $error("interrupt not raised");

  property p_irq_rel;
    (irq_status_i == '0) [*2] |-> irq_out_n_o;
  endproperty
  a_irq_rel: assert property (p_irq_rel) else $error("interrupt not released");

  property p_dsel;
    bus_32bit_i && !pins_s[PIN_DSEL] |=> data_high_sel_o && data_low_sel_o;
  endproperty
  a_dsel: assert property (p_dsel) else $error("data select not granted");

  property p_dsel16;
    !bus_32bit_i |=> !data_high_sel_o && !data_low_sel_o;
  endproperty
  a_dsel16: assert property (p_dsel16) else $error("data select in narrow mode");

  property p_ldev;
    !address_enable_i && addr_i[ADDR_HI:ADDR_LO] == base_addr_i[ADDR_HI:ADDR_LO]
      |-> !local_device_hit_n_o;
  endproperty
  a_ldev: assert property (p_ldev) else $error("local hit missing");

  property p_ldev_comb;
    $changed(local_device_hit_n_o) |->
      $changed(addr_i) || $changed(address_enable_i) || $changed(base_addr_i);
  endproperty
  a_ldev_comb: assert property (p_ldev_comb) else $error("local hit moved alone");

endmodule

// ### test/hbh_host_model.sv
// Purpose: host local bus controller model, bus clock and handshake pins
// Assumes: 5 MHz bus clock, far below the core clock
// Notes:   stall_i holds the ready return back to stretch a cycle
`timescale 1ns/1ps
module hbh_host_model (
  input  wire logic run_i,
  input  wire logic go_i,
  input  wire logic stall_i,
  input  wire logic sync_ready_n_i,
  output logic      bclk_o,
  output logic      cycle_indicator_n_o,
  output logic      host_ready_return_n_o
);
  // bus clock runs only while enabled, otherwise held low; one process drives every pin
  // reads here are synchronous only, so no read strobe is driven
  initial begin
    bclk_o                = 1'b0;
    cycle_indicator_n_o   = 1'b1;
    host_ready_return_n_o = 1'b1;
    #37;
    forever begin
      #100;
      if (bclk_o) begin
        // pins move on the falling bus clock so the device samples them settled
        cycle_indicator_n_o   <= ~go_i;
        host_ready_return_n_o <= sync_ready_n_i | stall_i;
      end
      bclk_o = run_i ? ~bclk_o : 1'b0;
    end
  end
endmodule

// ### test/tb_hbh_top.sv
// Purpose: self-checking bench of the host bus handshake and decode block
// Assumes: 40 MHz core clock, host model supplies the bus clock
// Notes:   strap is caught after reset, so burst mode needs a fresh reset
`timescale 1ns/1ps
module tb_hbh_top;
  import hbh_pkg::*;
  logic        clk_i, reset_n_i, strap, address_enable, dsel_n, bus32, burst, core_rdy, run, go, stall;
  logic [15:1] addr;
  logic [15:0] base;
  logic [15:0] irq;
  wire logic   bclk, cyc_n, rr_n, srdy_n, irq_n, hit_n, dhi, dlo, bm, cact;
  int          fails, compares;

  hbh_top dut (.clk_i(clk_i), .reset_n_i(reset_n_i), .bclk_i(bclk), .bus_mode_strap_i(strap),
    .host_ready_return_n_i(rr_n), .cycle_indicator_n_i(cyc_n), .data_port_select_n_i(dsel_n),
    .address_enable_i(address_enable), .addr_i(addr), .base_addr_i(base), .bus_32bit_i(bus32),
    .burst_mode_i(burst), .core_ready_i(core_rdy), .irq_status_i(irq), .sync_ready_n_o(srdy_n),
    .irq_out_n_o(irq_n), .local_device_hit_n_o(hit_n), .data_high_sel_o(dhi),
    .data_low_sel_o(dlo), .bus_burst_mode_o(bm), .cycle_active_o(cact));
  hbh_host_model host (.run_i(run), .go_i(go), .stall_i(stall), .sync_ready_n_i(srdy_n),
    .bclk_o(bclk), .cycle_indicator_n_o(cyc_n), .host_ready_return_n_o(rr_n));

  // core clock
  initial begin
    clk_i = 1'b0;
    forever #12.5 clk_i = ~clk_i;
  end

  task automatic chk(input string n, input logic e, input logic s);
    compares++;
    if (s !== e) begin
      fails++;
      $display("[ERR] %s expected %b seen %b", n, e, s);
    end
  endtask

  // bounded wait for the ready pin to reach a level
  task automatic wait_rdy(input logic v, input int lim);
    int k;
    k = 0;
    while (srdy_n !== v && k < lim) begin
      @(negedge clk_i);
      k++;
    end
    chk("sync_ready_n_o", v, srdy_n);
  endtask

  task automatic do_reset(input logic s);
    reset_n_i = 1'b0;
    strap = s;
    repeat (8) @(negedge clk_i);
    reset_n_i = 1'b1;
    repeat (6) @(negedge clk_i);
  endtask

  task automatic test_hit();
    logic [15:1] a [4];
    logic        e [4];
    a = '{15'h1d29, 15'h1d2f, 15'h1d21, 15'h5d28};
    e = '{1'b0, 1'b0, 1'b1, 1'b1};
    for (int i = 0; i < 4; i++) begin
      @(negedge clk_i);
      addr = a[i];
      #1 chk("local_device_hit_n_o", e[i], hit_n);
    end
    @(negedge clk_i);
    address_enable = 1'b1;
    addr = a[0];
    #1 chk("local_device_hit_n_o", 1'b1, hit_n);
    @(negedge clk_i);
    address_enable = 1'b0;
    $display("test local hit done");
  endtask

  task automatic test_irq();
    irq = 16'h0001;
    @(negedge clk_i);
    chk("irq_out_n_o", 1'b0, irq_n);
    irq = 16'h8000;
    @(negedge clk_i);
    chk("irq_out_n_o", 1'b0, irq_n);
    irq = 16'h0000;
    @(negedge clk_i);
    chk("irq_out_n_o", 1'b1, irq_n);
    $display("test interrupt done");
  endtask

  task automatic test_vl();
    core_rdy = 1'b1;
    stall = 1'b1;
    go = 1'b1;
    @(negedge bclk);
    @(negedge clk_i);
    go = 1'b0;
    wait_rdy(1'b0, 120);
    chk("cycle_active_o", 1'b1, cact);
    repeat (60) @(negedge clk_i);
    chk("sync_ready_n_o", 1'b0, srdy_n);
    stall = 1'b0;
    wait_rdy(1'b1, 120);
    address_enable = 1'b1;
    go = 1'b1;
    @(negedge bclk);
    @(negedge clk_i);
    go = 1'b0;
    repeat (80) @(negedge clk_i);
    chk("sync_ready_n_o", 1'b1, srdy_n);
    chk("cycle_active_o", 1'b0, cact);
    $display("test vl handshake done");
  endtask

  task automatic test_burst();
    bus32 = 1'b1;
    burst = 1'b1;
    core_rdy = 1'b0;
    addr = 15'h0000;
    do_reset(1'b1);
    chk("bus_burst_mode_o", 1'b1, bm);
    dsel_n = 1'b0;
    repeat (4) @(negedge clk_i);
    chk("data_high_sel_o", 1'b1, dhi);
    chk("data_low_sel_o", 1'b1, dlo);
    chk("cycle_active_o", 1'b1, cact);
    wait_rdy(1'b0, 40);
    repeat (30) @(negedge clk_i);
    chk("sync_ready_n_o", 1'b0, srdy_n);
    core_rdy = 1'b1;
    wait_rdy(1'b1, 40);
    bus32 = 1'b0;
    repeat (2) @(negedge clk_i);
    chk("data_high_sel_o", 1'b0, dhi);
    $display("test burst done");
  endtask

  task automatic print_verdict();
    $display("compares %0d fails %0d", compares, fails);
    if (fails == 0 && compares > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  // main sequence
  initial begin
    fails = 0;
    compares = 0;
    {address_enable, bus32, burst, core_rdy, run, go, stall} = '0;
    dsel_n = 1'b1;
    addr = '0;
    base = 16'h3a50;
    irq = '0;
    do_reset(1'b0);
    run = 1'b1;
    test_hit();
    test_irq();
    test_vl();
    test_burst();
    print_verdict();
  end

  // watchdog, about sixty times the expected run
  initial begin
    #400000;
    fails++;
    print_verdict();
  end
endmodule
